/* hdl/eis_map.svh */
// constants and operating overview for the serial memory front end
// Overview of operation
// R1: select only when straps equal control bits
// R2: data line carries address, data in, data out
// R3: data output only pulls low or releases
// R4: data changes only while clock is low
// R5: data falling with clock high is start
// R6: data rising with clock high is stop
// R7: only the master makes start and stop
// R8: bus busy from start until after stop
// R9: idle bus: nobody drives, lines rest high
// R10: clock pin is input only, never driven
// R11: each byte is eight bits plus acknowledge
// R12: bits travel most significant first
// R13: no byte count limit per transfer
// R14: master keeps serial clock at most 1MHz
// R15: write protect high blocks array writes
// R16: write protect low allows array writes
// R17: byte writes and page writes of 1 to 32
// R18: page write within 0.7 ms, byte 30 us
// R19: random and sequential reads, whole array
// R20: control byte: code 1010, straps, direction
// R21: direction one reads, zero writes
// R22: acknowledge control byte on ninth pulse
// R23: no acknowledge while write cycle runs
// R24: synchronise and filter lines before detection
// R25: start restarts framing, stop returns idle
// R26: mismatch releases line until next start
`ifndef EIS_MAP_SVH
`define EIS_MAP_SVH
`define EIS_CTRL_CODE 4'ha
`define EIS_ADDR_W 13
`define EIS_MEM_BYTES 8192
`define EIS_PAGE_BYTES 32
`define EIS_NLINES 6
`define EIS_LN_SCL 0
`define EIS_LN_SDA 1
`define EIS_LN_WP 2
`define EIS_LINE_RST 6'h03
`define EIS_ACK_BIT 4'h8
`define EIS_END_BIT 4'h9
`define EIS_CLK_SYS_NS 25
`define EIS_T_BYTE_NS 30000
`define EIS_T_PAGE_NS 700000
`define EIS_BYTE_CYC (`EIS_T_BYTE_NS / `EIS_CLK_SYS_NS)
`define EIS_PAGE_CYC (`EIS_T_PAGE_NS / `EIS_CLK_SYS_NS)
`endif

/* hdl/eis_pkg.sv */
// types shared by the serial memory front end
`include "eis_map.svh"
package eis_pkg;
    typedef enum logic [6:0] {
        ST_IDLE = 7'h01,
        ST_CTRL = 7'h02,
        ST_ADDR_HI = 7'h04,
        ST_ADDR_LO = 7'h08,
        ST_WDATA = 7'h10,
        ST_RDATA = 7'h20,
        ST_IGNORE = 7'h40
    } eis_state_t;
    typedef struct packed {
        logic [`EIS_NLINES-1:0] s1;
        logic [`EIS_NLINES-1:0] s2;
        logic [`EIS_NLINES-1:0] h;
        logic [`EIS_NLINES-1:0] o;
    } eis_flt_t;
    typedef struct packed {
        logic req_s1;
        logic req_s2;
        logic req_prev;
        logic done_tgl;
        logic run;
        logic [15:0] cnt;
    } eis_wc_t;
endpackage

/* hdl/eis_wc_if.sv */
// handshake carrier between link front end and write cycle timer
`timescale 1ns/1ps
`default_nettype none
interface eis_wc_if;
    logic req_tgl;
    logic [5:0] nbytes;
    logic done_tgl;
    modport link (output req_tgl, output nbytes, input done_tgl);
    modport sys (input req_tgl, input nbytes, output done_tgl);
endinterface
`default_nettype wire

/* hdl/eis_line_filter.sv */
// pin synchroniser and glitch filter, one lane per line
`timescale 1ns/1ps
`default_nettype none
`include "eis_map.svh"
module eis_line_filter (
    input wire logic clk, // link clock
    input wire logic rst_n, // link reset, active low
    input wire logic [`EIS_NLINES-1:0] raw, // asynchronous pins
    output logic [`EIS_NLINES-1:0] clean // filtered levels
);
    eis_pkg::eis_flt_t q, n;

    // ------------------------------------------------------------
    // two flops, then accept a level only when two samples agree
    // ------------------------------------------------------------
    always_comb begin
        n = q;
        n.s1 = raw;
        n.s2 = q.s1;
        n.h = q.s2;
        for (int i = 0; i < `EIS_NLINES; i++) begin
            if (q.s2[i] == q.h[i]) begin
                n.o[i] = q.h[i]; // see R24
            end
        end
    end

    // state register; clock and data idle high so reset matches a free bus
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            q <= {4{`EIS_LINE_RST}};
        end else begin
            q <= n;
        end
    end

    assign clean = q.o;
endmodule
`default_nettype wire

/* hdl/eis_wcycle.sv */
// write cycle timer on the internal clock
`timescale 1ns/1ps
`default_nettype none
`include "eis_map.svh"
module eis_wcycle #(
    parameter int unsigned PAGE_CYC = `EIS_PAGE_CYC // full page time
) (
    input wire logic clk_sys, // internal clock
    input wire logic rstn, // sync reset, active low
    eis_wc_if.sys wc // toggle request, byte count, done toggle
);
    eis_pkg::eis_wc_t q, n;
    logic [15:0] lim;
    logic [15:0] prod;

    // ------------------------------------------------------------
    // duration grows per byte but never passes the page figure
    // ------------------------------------------------------------
    always_comb begin
        n = q;
        prod = 16'(wc.nbytes) * 16'(`EIS_BYTE_CYC);
        lim = (prod > 16'(PAGE_CYC)) ? 16'(PAGE_CYC) : prod;
        n.req_s1 = wc.req_tgl;
        n.req_s2 = q.req_s1;
        n.req_prev = q.req_s2;
        // nbytes is held by the link side until done comes back
        if (q.req_s2 != q.req_prev) begin
            n.run = 1'b1;
            n.cnt = lim; // see R18
        end else if (q.run) begin
            if (q.cnt <= 16'h0001) begin
                n.run = 1'b0;
                n.done_tgl = ~q.done_tgl;
            end else begin
                n.cnt = q.cnt - 16'h0001;
            end
        end
    end

    // state register
    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            q <= '0;
        end else begin
            q <= n;
        end
    end

    assign wc.done_tgl = q.done_tgl;
endmodule
`default_nettype wire

/* hdl/eis_top.sv */
// two-wire slave front end with array, page buffer and write timing
`timescale 1ns/1ps
`default_nettype none
`include "eis_map.svh"
module eis_top #(
    parameter int unsigned PAGE_CYC = `EIS_PAGE_CYC // page write cycles
) (
    input wire logic clk_sys, // internal clock, 40 MHz
    input wire logic rstn, // sync reset, active low
    input wire logic clk_link, // front end sampling clock
    input wire logic scl_i, // serial clock pin level
    input wire logic sda_i, // serial data pin level
    output logic sda_o, // data drive value, always low
    output logic sda_oe, // high while pulling data low
    input wire logic select_strap_lsb, // strap, low select bit
    input wire logic select_strap_mid, // strap, middle select bit
    input wire logic select_strap_msb, // strap, high select bit
    input wire logic wr_protect_i, // high blocks array writes
    output logic wr_busy // high while write cycle runs
);

    // ------------------------------------------------------------
    // link state, one packed record
    // ------------------------------------------------------------
    typedef struct packed {
        eis_pkg::eis_state_t st;
        logic [3:0] bitcnt;
        logic [7:0] sh;
        logic [7:0] rd;
        logic [`EIS_ADDR_W-1:0] addr;
        logic [`EIS_PAGE_BYTES-1:0] mask;
        logic [`EIS_PAGE_BYTES-1:0] cmask;
        logic [5:0] wcnt;
        logic [4:0] cidx;
        logic cbusy;
        logic busy;
        logic req_tgl;
        logic [5:0] nbytes;
        logic done_s1;
        logic done_s2;
        logic done_prev;
        logic scl_prev;
        logic sda_prev;
        logic oe;
        logic lo;
    } eis_link_t;

    eis_link_t q, n;

    // link reset taken from the internal reset through two flops
    logic rst_s1, rst_s2;
    logic link_rstn;

    // filtered line levels
    logic [`EIS_NLINES-1:0] raw;
    logic [`EIS_NLINES-1:0] ln;
    logic scl, sda, wp;
    logic [2:0] straps;

    // decoded bus events
    logic start, stop, rise, fall;
    logic match;

    // array and page buffer
    logic [7:0] mem_q [0:`EIS_MEM_BYTES-1];
    logic [7:0] pbuf_q [0:`EIS_PAGE_BYTES-1];
    logic mem_we;
    logic [`EIS_ADDR_W-1:0] mem_wa;
    logic [7:0] mem_wd;
    logic pb_we;
    logic [4:0] pb_wa;
    logic [7:0] pb_wd;
    logic [7:0] mem_rd;

    eis_wc_if wc ();

    // ------------------------------------------------------------
    // reset crossing into the link domain
    // ------------------------------------------------------------
    // these two flops carry the reset itself, so they have none
    always_ff @(posedge clk_link) begin
        rst_s1 <= rstn;
        rst_s2 <= rst_s1;
    end
    assign link_rstn = rst_s2;

    // ------------------------------------------------------------
    // pin conditioning
    // ------------------------------------------------------------
    // all pins share one filter so straps and protect are also clean
    assign raw = {select_strap_msb, select_strap_mid, select_strap_lsb,
                  wr_protect_i, sda_i, scl_i};

    eis_line_filter u_filter (
        .clk(clk_link),
        .rst_n(link_rstn),
        .raw(raw),
        .clean(ln)
    );

    assign scl = ln[`EIS_LN_SCL]; // see R10
    assign sda = ln[`EIS_LN_SDA];
    assign wp = ln[`EIS_LN_WP];
    assign straps = ln[`EIS_NLINES-1:`EIS_NLINES-3];

    // ------------------------------------------------------------
    // bus condition decode
    // ------------------------------------------------------------
    // data may only move while clock is low, so a data edge
    // seen with clock high on both samples is a condition
    assign start = scl && q.scl_prev && q.sda_prev && !sda; // see R5
    assign stop = scl && q.scl_prev && !q.sda_prev && sda; // see R6
    assign rise = scl && !q.scl_prev; // see R4
    assign fall = !scl && q.scl_prev;

    // control byte compare: fixed code, straps, not busy
    assign match = (q.sh[7:4] == `EIS_CTRL_CODE) // see R20
                   && (q.sh[3:1] == straps) // see R1
                   && !q.busy; // see R23

    assign mem_rd = mem_q[q.addr];

    // ------------------------------------------------------------
    // link next state
    // ------------------------------------------------------------
    always_comb begin
        n = q;
        mem_we = 1'b0;
        mem_wa = '0;
        mem_wd = 8'h00;
        pb_we = 1'b0;
        pb_wa = 5'h00;
        pb_wd = 8'h00;
        n.lo = 1'b0; // see R3
        n.scl_prev = scl;
        n.sda_prev = sda;

        // done toggle from the timer, two flops then edge compare
        n.done_s1 = wc.done_tgl;
        n.done_s2 = q.done_s1;
        n.done_prev = q.done_s2;
        if (q.done_s2 != q.done_prev) begin
            n.busy = 1'b0;
        end

        // commit the latched page, one byte per link clock
        if (q.cbusy) begin
            if (q.cmask[q.cidx]) begin
                mem_we = 1'b1; // see R16
                mem_wa = {q.addr[`EIS_ADDR_W-1:5], q.cidx};
                mem_wd = pbuf_q[q.cidx];
            end
            n.cidx = q.cidx + 5'h01;
            if (q.cidx == 5'h1f) begin
                n.cbusy = 1'b0;
            end
        end

        if (start) begin
            // repeated start also lands here and drops pending data
            n.st = eis_pkg::ST_CTRL; // see R8
            n.bitcnt = 4'h0; // see R25
            n.oe = 1'b0;
            n.mask = '0;
            n.wcnt = 6'h00;
        end else if (stop) begin
            // the stop alone launches the write; protect sampled here
            if (q.st == eis_pkg::ST_WDATA && q.wcnt != 6'h00
                && !wp) begin // see R15
                n.cmask = q.mask;
                n.cbusy = 1'b1;
                n.cidx = 5'h00;
                n.busy = 1'b1;
                n.req_tgl = ~q.req_tgl;
                n.nbytes = q.wcnt; // see R18
            end
            n.st = eis_pkg::ST_IDLE; // see R25
            n.bitcnt = 4'h0;
            n.oe = 1'b0; // see R9
        end else if (q.st != eis_pkg::ST_IDLE
                     && q.st != eis_pkg::ST_IGNORE) begin // see R26
            if (rise) begin
                if (q.bitcnt < `EIS_ACK_BIT) begin
                    n.sh = {q.sh[6:0], sda}; // see R12
                end else if (q.st == eis_pkg::ST_RDATA && !q.oe) begin
                    // master acknowledge on the ninth pulse; while we still
                    // drive our own control byte ack the slot is not theirs
                    if (sda) begin
                        n.st = eis_pkg::ST_IGNORE;
                    end else begin
                        n.addr = q.addr + 13'h0001; // see R19
                    end
                end
                n.bitcnt = q.bitcnt + 4'h1; // see R11
            end else if (fall) begin
                case (q.bitcnt)
                    `EIS_ACK_BIT: begin
                        case (q.st)
                            eis_pkg::ST_CTRL: begin
                                if (match) begin
                                    n.oe = 1'b1; // see R22
                                    n.st = q.sh[0] ? eis_pkg::ST_RDATA
                                                   : eis_pkg::ST_ADDR_HI; // see R21
                                end else begin
                                    n.st = eis_pkg::ST_IGNORE; // see R26
                                end
                            end
                            eis_pkg::ST_ADDR_HI: begin
                                n.oe = 1'b1;
                                n.addr[`EIS_ADDR_W-1:8] = q.sh[4:0];
                                n.st = eis_pkg::ST_ADDR_LO;
                            end
                            eis_pkg::ST_ADDR_LO: begin
                                n.oe = 1'b1;
                                n.addr[7:0] = q.sh;
                                n.st = eis_pkg::ST_WDATA;
                            end
                            eis_pkg::ST_WDATA: begin
                                // buffer by page offset so overflow wraps
                                n.oe = 1'b1; // see R13
                                pb_we = 1'b1; // see R17
                                pb_wa = q.addr[4:0];
                                pb_wd = q.sh;
                                n.mask[q.addr[4:0]] = 1'b1;
                                n.addr[4:0] = q.addr[4:0] + 5'h01;
                                if (q.wcnt != 6'(`EIS_PAGE_BYTES)) begin
                                    n.wcnt = q.wcnt + 6'h01;
                                end
                            end
                            default: begin
                                n.oe = 1'b0; // release for master ack
                            end
                        endcase
                    end
                    `EIS_END_BIT: begin
                        n.bitcnt = 4'h0;
                        n.oe = 1'b0;
                        if (q.st == eis_pkg::ST_RDATA) begin
                            n.rd = mem_rd; // see R2
                            n.oe = ~mem_rd[7]; // see R12
                        end
                    end
                    default: begin
                        // drive the next read bit while clock is low
                        if (q.st == eis_pkg::ST_RDATA
                            && q.bitcnt != 4'h0) begin
                            n.oe = ~q.rd[3'(4'h7 - q.bitcnt)]; // see R4
                        end
                    end
                endcase
            end
        end else begin
            n.oe = 1'b0; // see R26
        end
    end

    // ------------------------------------------------------------
    // link state register
    // ------------------------------------------------------------
    always_ff @(posedge clk_link) begin
        if (!link_rstn) begin
            q <= '0;
            q.st <= eis_pkg::ST_IDLE;
            q.scl_prev <= 1'b1;
            q.sda_prev <= 1'b1;
        end else begin
            q <= n;
        end
    end

    // ------------------------------------------------------------
    // storage
    // ------------------------------------------------------------
    // array has no reset; contents are undefined until written
    always_ff @(posedge clk_link) begin
        if (mem_we) begin
            mem_q[mem_wa] <= mem_wd;
        end
    end

    always_ff @(posedge clk_link) begin
        if (pb_we) begin
            pbuf_q[pb_wa] <= pb_wd;
        end
    end

    // ------------------------------------------------------------
    // write cycle timer on the internal clock
    // ------------------------------------------------------------
    assign wc.req_tgl = q.req_tgl;
    assign wc.nbytes = q.nbytes;

    eis_wcycle #(
        .PAGE_CYC(PAGE_CYC)
    ) u_wcycle (
        .clk_sys(clk_sys),
        .rstn(rstn),
        .wc(wc)
    );

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign sda_o = q.lo; // open drain: value is low, enable pulls
    assign sda_oe = q.oe;
    assign wr_busy = q.busy;

endmodule
`default_nettype wire

/* verification/eis_top_properties.sv */
// assertion checker for the serial memory front end, bound to its top
`timescale 1ns/1ps
`default_nettype none
module eis_top_properties #(
    parameter int unsigned PAGE_CYC = 200 // page write cycles
) (
    input wire logic clk_sys, // internal clock
    input wire logic rstn, // sync reset, active low
    input wire logic clk_link, // link clock
    input wire logic scl_i, // clock line level
    input wire logic sda_i, // data line level
    input wire logic sda_o, // data drive value
    input wire logic sda_oe, // data pull enable
    input wire logic select_strap_lsb, // strap low
    input wire logic select_strap_mid, // strap middle
    input wire logic select_strap_msb, // strap high
    input wire logic wr_protect_i, // write protect
    input wire logic wr_busy // write cycle running
);
    logic [15:0] busy_cnt_q;
    // ----------------------------------------
    // length of one busy spell in clk_sys cycles
    // ----------------------------------------
    always_ff @(posedge clk_sys) begin
        if (!rstn || !wr_busy) begin
            busy_cnt_q <= 16'h0000;
        end else begin
            busy_cnt_q <= busy_cnt_q + 16'h0001;
        end
    end
    a_drive_low_only: assert property (@(posedge clk_link) disable iff (!rstn)
        sda_oe |-> sda_o == 1'b0) else $error("data driven high");
    a_oe_moves_scl_low: assert property (@(posedge clk_link) disable iff (!rstn)
        $changed(sda_oe) |-> !scl_i) else $error("data drive moved while clock high");
    a_ack_after_fall: assert property (@(posedge clk_link) disable iff (!rstn)
        $rose(sda_oe) |-> !$past(scl_i, 3)) else $error("drive began too soon after clock fall");
    a_quiet_after_start: assert property (@(posedge clk_link) disable iff (!rstn)
        scl_i && $past(scl_i) && $fell(sda_i) |-> !sda_oe [*8]) else $error("drive right after start");
    a_quiet_after_stop: assert property (@(posedge clk_link) disable iff (!rstn)
        scl_i && $past(scl_i) && $rose(sda_i) |-> !sda_oe [*8]) else $error("drive right after stop");
    a_silent_when_busy: assert property (@(posedge clk_link) disable iff (!rstn)
        wr_busy && $past(wr_busy, 4) |-> !sda_oe) else $error("acknowledge during write cycle");
    a_busy_from_idle: assert property (@(posedge clk_link) disable iff (!rstn)
        $rose(wr_busy) |-> scl_i && sda_i && !wr_protect_i) else $error("write cycle began wrongly");
    a_busy_bounded: assert property (@(posedge clk_sys) disable iff (!rstn)
        {16'h0000, busy_cnt_q} <= PAGE_CYC + 32'd64) else $error("write cycle too long");
endmodule
bind eis_top eis_top_properties #(.PAGE_CYC(PAGE_CYC)) u_props (.clk_sys(clk_sys), .rstn(rstn),
    .clk_link(clk_link), .scl_i(scl_i), .sda_i(sda_i), .sda_o(sda_o), .sda_oe(sda_oe),
    .select_strap_lsb(select_strap_lsb), .select_strap_mid(select_strap_mid),
    .select_strap_msb(select_strap_msb), .wr_protect_i(wr_protect_i), .wr_busy(wr_busy));
`default_nettype wire

/* verification/eis_master.sv */
// two-wire bus master model that talks to the front end
`timescale 1ns/1ps
`default_nettype none
module eis_master #(
    parameter int Q = 40 // clk cycles per quarter bit, 250 kHz keeps under 1MHz
) (
    input wire logic clk, // bench clock
    input wire logic sda_i, // wired data level
    output var logic scl_low, // high pulls clock line low
    output var logic sda_low // high pulls data line low
);
    // both lines released at rest
    initial begin
        scl_low = 1'b0;
        sda_low = 1'b0;
    end
    // one bit: data moves only mid low phase, sampled mid high phase
    task automatic bit_io(input logic b, output logic r);
        repeat (Q) @(posedge clk);
        sda_low <= !b;
        repeat (Q) @(posedge clk);
        scl_low <= 1'b0;
        repeat (Q) @(posedge clk);
        r = sda_i;
        repeat (Q) @(posedge clk);
        scl_low <= 1'b1;
    endtask
    // start or repeated start, only the master makes it
    task automatic start();
        repeat (Q) @(posedge clk);
        sda_low <= 1'b0;
        repeat (Q) @(posedge clk);
        scl_low <= 1'b0;
        repeat (Q) @(posedge clk);
        sda_low <= 1'b1;
        repeat (Q) @(posedge clk);
        scl_low <= 1'b1;
    endtask
    // stop leaves the bus free and high
    task automatic stop();
        repeat (Q) @(posedge clk);
        sda_low <= 1'b1;
        repeat (Q) @(posedge clk);
        scl_low <= 1'b0;
        repeat (Q) @(posedge clk);
        sda_low <= 1'b0;
        repeat (2 * Q) @(posedge clk);
    endtask
    // eight bits msb first then the acknowledge slot
    task automatic xfer(input logic [7:0] tx, input logic slot, output logic [7:0] rx, output logic nack);
        for (int i = 7; i >= 0; i--) begin
            bit_io(tx[i], rx[i]);
        end
        bit_io(slot, nack);
    endtask
endmodule
`default_nettype wire

/* verification/eis_top_tb.sv */
// self-checking bench for the serial memory front end
`timescale 1ns/1ps
`default_nettype none
module eis_top_tb;
    localparam logic [7:0] CW = 8'haa; // code 1010, straps 101, write
    localparam logic [7:0] CR = 8'hab; // same, read
    logic clk_sys, clk_link, rstn, wp, sda_oe, sda_o, wr_busy, m_scl_low, m_sda_low, scl, sda;
    logic [2:0] strap;
    int err_count = 0;
    int n_checks = 0;
    assign scl = !m_scl_low;
    assign sda = !(m_sda_low || sda_oe === 1'b1); // wired-and with pull-up
    eis_top #(.PAGE_CYC(4000)) dut (.clk_sys(clk_sys), .rstn(rstn), .clk_link(clk_link), .scl_i(scl),
        .sda_i(sda), .sda_o(sda_o), .sda_oe(sda_oe), .select_strap_lsb(strap[0]), .select_strap_mid(strap[1]),
        .select_strap_msb(strap[2]), .wr_protect_i(wp), .wr_busy(wr_busy));
    eis_master m (.clk(clk_sys), .sda_i(sda), .scl_low(m_scl_low), .sda_low(m_sda_low));
    // ----------------------------------------
    // clocks, the link one free of the other in phase
    // ----------------------------------------
    initial begin
        clk_sys = 1'b0;
        forever #12.5 clk_sys = ~clk_sys;
    end
    initial begin
        clk_link = 1'b0;
        #37;
        forever #80 clk_link = ~clk_link;
    end
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        n_checks++;
        if (got !== exp) begin
            err_count++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic put(input logic [7:0] b, input logic ack_exp);
        logic [7:0] rx;
        logic nk;
        m.xfer(b, 1'b1, rx, nk);
        chk("acknowledge", {7'h00, ack_exp}, {7'h00, !nk});
    endtask
    task automatic get(input logic [7:0] exp, input logic last);
        logic [7:0] rx;
        logic nk;
        m.xfer(8'hff, last, rx, nk);
        chk("read data", exp, rx);
    endtask
    task automatic addr_cmd(input logic [15:0] a);
        m.start();
        put(CW, 1'b1);
        put(a[15:8], 1'b1);
        put(a[7:0], 1'b1);
    endtask
    // random read, repeated start then one or two sequential bytes
    task automatic rd(input logic [15:0] a, input logic [15:0] exp, input int n);
        addr_cmd(a);
        m.start();
        put(CR, 1'b1);
        get(exp[15:8], n == 1);
        if (n == 2) begin
            get(exp[7:0], 1'b1);
        end
        m.stop();
    endtask
    task automatic wait_idle();
        int k;
        for (k = 0; k < 6000 && wr_busy !== 1'b0; k++) begin
            @(posedge clk_sys);
        end
        chk("busy end", 8'h00, {7'h00, wr_busy});
    endtask
    task automatic t_byte_write();
        addr_cmd(16'h0123);
        put(8'h5a, 1'b1);
        m.stop();
        repeat (100) @(posedge clk_sys);
        chk("busy", 8'h01, {7'h00, wr_busy});
        wait_idle();
        rd(16'h0123, 16'h5a00, 1);
    endtask
    task automatic t_select();
        for (int e = 0; e < 8; e++) begin
            m.start();
            put({4'ha, e[2:0], 1'b0}, e == 5);
            m.stop();
        end
        // move the straps while the bus rests; old code must now be refused
        strap <= 3'h2;
        repeat (40) @(posedge clk_sys);
        m.start();
        put(8'ha4, 1'b1);
        m.stop();
        m.start();
        put(CW, 1'b0);
        m.stop();
        strap <= 3'h5;
        repeat (40) @(posedge clk_sys);
        m.start();
        put(8'hba, 1'b0);
        put(CW, 1'b0);
        m.stop();
    endtask
    task automatic t_page_poll();
        logic [7:0] rx;
        logic nk;
        addr_cmd(16'h1f1e);
        for (int i = 0; i < 4; i++) begin
            put(8'hc0 + 8'(i), 1'b1);
        end
        m.stop();
        m.start();
        put(CW, 1'b0);
        m.stop();
        nk = 1'b1;
        for (int i = 0; i < 6 && nk; i++) begin
            m.start();
            m.xfer(CW, 1'b1, rx, nk);
            m.stop();
        end
        chk("poll acknowledge", 8'h00, {7'h00, nk});
        rd(16'h1f1e, 16'hc0c1, 2);
        rd(16'h1f00, 16'hc2c3, 2);
    endtask
    task automatic t_protect();
        wp <= 1'b1;
        addr_cmd(16'h0123);
        put(8'h77, 1'b1);
        m.stop();
        repeat (200) @(posedge clk_sys);
        chk("busy", 8'h00, {7'h00, wr_busy});
        wp <= 1'b0;
        rd(16'h0123, 16'h5a00, 1);
    endtask
    task automatic conclude();
        $display("checks %0d mismatches %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    // watchdog, about an eighth beyond the expected run
    initial begin
        repeat (96000) @(posedge clk_sys);
        err_count++;
        conclude();
    end
    // reset long enough for the link side too, then the scenarios
    initial begin
        rstn = 1'b0;
        wp = 1'b0;
        strap = 3'h5;
        repeat (16) @(posedge clk_link);
        @(posedge clk_sys);
        rstn <= 1'b1;
        repeat (4) @(posedge clk_link);
        @(posedge clk_sys);
        t_byte_write();
        t_select();
        t_page_poll();
        t_protect();
        conclude();
    end
endmodule
`default_nettype wire
